/* hdl/dbap_port.sv */
`timescale 1ns/100ps
// Requests enter a FIFO: {write, byte enables, row, col, data}. A request with a
// new row closes the open page first; reads return on rd_data_o/rd_valid_o.
module dbap_port #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic req_write_i,
  input wire logic [1:0] req_byte_en_i,
  input wire logic [dbap_pkg::ROW_W-1:0] req_row_i,
  input wire logic [dbap_pkg::COL_W-1:0] req_col_i,
  input wire logic [dbap_pkg::DATA_W-1:0] req_wdata_i,
  output logic [dbap_pkg::DATA_W-1:0] rd_data_o,
  output logic rd_valid_o,
  output logic [dbap_pkg::CFG_W-1:0] strap_config_word_o,
  output logic strap_done_o,
  input wire logic [dbap_pkg::DATA_W-1:0] bank_a_mem_data_i,
  output logic [dbap_pkg::DATA_W-1:0] bank_a_mem_data_o,
  output logic bank_a_mem_data_oe_o,
  input wire logic [dbap_pkg::DATA_W-1:0] bank_b_mem_data_i,
  output logic [dbap_pkg::ROW_W-1:0] bank_a_addr_o,
  output logic bank_a_row_strobe_n_o,
  output logic bank_a_col_strobe_lo_n_o,
  output logic bank_a_col_strobe_hi_n_o,
  output logic bank_a_write_en_n_o,
  output logic bank_a_output_en_n_o
);
  localparam int DW = dbap_pkg::DATA_W;
  localparam int RW = dbap_pkg::ROW_W;
  localparam int CW = dbap_pkg::COL_W;
  localparam int QW = 1 + 2 + RW + CW + DW;

  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("FIFO_DEPTH too small");
  end

  // Pins come from outside the clock domain: two flops before use.
  logic [DW-1:0] a_meta_r;
  logic [DW-1:0] a_sync_r;
  logic [DW-1:0] b_meta_r;
  logic [DW-1:0] b_sync_r;
  always_ff @(posedge clk_i) begin
    a_meta_r <= bank_a_mem_data_i;
    a_sync_r <= a_meta_r;
    b_meta_r <= bank_b_mem_data_i;
    b_sync_r <= b_meta_r;
  end

  // Request FIFO; the sequencer stalls it, so back-pressure reaches req_ready_o.
  logic [QW-1:0] q_data;
  logic q_valid;
  logic q_pop;
  dbap_fifo #(.WIDTH(QW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_data_i({req_write_i, req_byte_en_i, req_row_i, req_col_i, req_wdata_i}),
    .in_valid_i(req_valid_i),
    .in_ready_o(req_ready_o),
    .out_data_o(q_data),
    .out_valid_o(q_valid),
    .out_ready_i(q_pop)
  );

  logic q_wr;
  logic [1:0] q_be;
  logic [RW-1:0] q_row;
  logic [CW-1:0] q_col;
  logic [DW-1:0] q_wd;
  assign {q_wr, q_be, q_row, q_col, q_wd} = q_data;

  dbap_pkg::dbap_state_t state_r;
  logic [3:0] cnt_r;
  logic [RW-1:0] open_row_r;
  logic page_open_r;
  logic cur_wr_r;

  // The request is taken as its column cycle starts.
  assign q_pop = (state_r == dbap_pkg::DBAP_IDLE || state_r == dbap_pkg::DBAP_CPRE)
                 && q_valid && page_open_r && (q_row == open_row_r) && (cnt_r == dbap_pkg::CNT_ZERO);

  // Sequencer: strap capture, then page open, column cycles, precharge.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= dbap_pkg::DBAP_CAPT;
      cnt_r <= 4'(dbap_pkg::STRAP_CYC);
      page_open_r <= 1'b0;
      open_row_r <= '0;
      cur_wr_r <= 1'b0;
    end else begin
      if (cnt_r != dbap_pkg::CNT_ZERO) cnt_r <= cnt_r - 4'h1;
      case (state_r)
        dbap_pkg::DBAP_CAPT: begin
          if (cnt_r == dbap_pkg::CNT_ZERO) state_r <= dbap_pkg::DBAP_IDLE;
        end
        dbap_pkg::DBAP_IDLE, dbap_pkg::DBAP_CPRE: begin
          if (cnt_r == dbap_pkg::CNT_ZERO && q_valid) begin
            if (q_pop) begin
              state_r <= dbap_pkg::DBAP_CAS;
              cur_wr_r <= q_wr;
              cnt_r <= 4'(dbap_pkg::TCAS_CYC - 1);
            end else if (page_open_r) begin
              state_r <= dbap_pkg::DBAP_RP;
              page_open_r <= 1'b0;
              cnt_r <= 4'(dbap_pkg::TRP_CYC - 1);
            end else begin
              state_r <= dbap_pkg::DBAP_RCD;
              page_open_r <= 1'b1;
              open_row_r <= q_row;
              cnt_r <= 4'(dbap_pkg::TRCD_CYC - 1);
            end
          end
        end
        dbap_pkg::DBAP_RCD: begin
          if (cnt_r == dbap_pkg::CNT_ZERO) state_r <= dbap_pkg::DBAP_CPRE;
        end
        dbap_pkg::DBAP_CAS: begin
          if (cnt_r == dbap_pkg::CNT_ZERO) state_r <= dbap_pkg::DBAP_CPRE;
        end
        dbap_pkg::DBAP_RP: begin
          if (cnt_r == dbap_pkg::CNT_ZERO) state_r <= dbap_pkg::DBAP_IDLE;
        end
        default: state_r <= dbap_pkg::DBAP_IDLE;
      endcase
    end
  end

  // Strap word: bank A low half with bits 8 and 11 swapped, bank B high half.
  // Sampled while lines are released, after the two-flop synchroniser settles.
  logic [dbap_pkg::CFG_W-1:0] strap_nxt;
  always_comb begin
    strap_nxt[dbap_pkg::CFG_W-1:dbap_pkg::CFG_HI_LSB] = b_sync_r;
    strap_nxt[DW-1:0] = a_sync_r;
    strap_nxt[dbap_pkg::SWAP_A] = a_sync_r[dbap_pkg::SWAP_B];
    strap_nxt[dbap_pkg::SWAP_B] = a_sync_r[dbap_pkg::SWAP_A];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_config_word_o <= '0;
      strap_done_o <= 1'b0;
    end else if (state_r == dbap_pkg::DBAP_CAPT && cnt_r == dbap_pkg::CNT_ZERO) begin
      strap_config_word_o <= strap_nxt;
      strap_done_o <= 1'b1;
    end
  end

  // DRAM pins, all registered. The 256Kx16 part uses both CAS strobes; x4 parts
  // pair on the low and high strobes, so the same pinout serves both.
  logic col_go;
  assign col_go = q_pop;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bank_a_addr_o <= '0;
      bank_a_row_strobe_n_o <= 1'b1;
      bank_a_col_strobe_lo_n_o <= 1'b1;
      bank_a_col_strobe_hi_n_o <= 1'b1;
      bank_a_write_en_n_o <= 1'b1;
      bank_a_output_en_n_o <= 1'b1;
      bank_a_mem_data_o <= '0;
      bank_a_mem_data_oe_o <= 1'b0;
    end else begin
      bank_a_col_strobe_lo_n_o <= 1'b1;
      bank_a_col_strobe_hi_n_o <= 1'b1;
      bank_a_write_en_n_o <= 1'b1;
      bank_a_output_en_n_o <= 1'b1;
      bank_a_mem_data_oe_o <= 1'b0;
      if (state_r == dbap_pkg::DBAP_IDLE && cnt_r == dbap_pkg::CNT_ZERO && q_valid
          && !page_open_r) begin
        bank_a_addr_o <= q_row;
        bank_a_row_strobe_n_o <= 1'b0;
      end else if (state_r == dbap_pkg::DBAP_CPRE && cnt_r == dbap_pkg::CNT_ZERO
                   && q_valid && !q_pop) begin
        bank_a_row_strobe_n_o <= 1'b1;
      end
      if (col_go) begin
        bank_a_addr_o <= q_col;
        bank_a_col_strobe_lo_n_o <= ~q_be[0];
        bank_a_col_strobe_hi_n_o <= ~q_be[1];
        bank_a_write_en_n_o <= ~q_wr;
        bank_a_output_en_n_o <= q_wr;
        bank_a_mem_data_o <= q_wd;
        bank_a_mem_data_oe_o <= q_wr;
      end
    end
  end

  // Read data stands on the pins in the cycle after the column pulse starts and then
  // crosses both synchroniser flops; taking it any earlier would catch the idle level.
  localparam int RD_PIPE = 3;
  logic [RD_PIPE-1:0] rd_dly_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_dly_r <= '0;
      rd_valid_o <= 1'b0;
      rd_data_o <= '0;
    end else begin
      rd_dly_r <= {rd_dly_r[RD_PIPE-2:0], col_go && !q_wr};
      rd_valid_o <= rd_dly_r[RD_PIPE-1];
      if (rd_dly_r[RD_PIPE-1]) rd_data_o <= a_sync_r;
    end
  end

  // Lines released for the whole capture window.
  property p_release_capt;
    @(posedge clk_i) disable iff (rst_i)
      (state_r == dbap_pkg::DBAP_CAPT) |-> !bank_a_mem_data_oe_o;
  endproperty
  a_release_capt: assert property (p_release_capt) else $error("Data driven during capture");

  // Column strobes only fall while row strobe is low.
  property p_cas_under_ras;
    @(posedge clk_i) disable iff (rst_i)
      (!bank_a_col_strobe_lo_n_o || !bank_a_col_strobe_hi_n_o) |-> !bank_a_row_strobe_n_o;
  endproperty
  a_cas_under_ras: assert property (p_cas_under_ras) else $error("CAS without RAS");

  // Write and output enable never low together.
  property p_we_oe_excl;
    @(posedge clk_i) disable iff (rst_i)
      !(!bank_a_write_en_n_o && !bank_a_output_en_n_o);
  endproperty
  a_we_oe_excl: assert property (p_we_oe_excl) else $error("WE and OE both low");

  // Strap word bits 8 and 11 take the swapped bank A lines.
  property p_swap;
    @(posedge clk_i) disable iff (rst_i)
      $rose(strap_done_o) |->
        strap_config_word_o[dbap_pkg::SWAP_A] == $past(a_sync_r[dbap_pkg::SWAP_B]) &&
        strap_config_word_o[dbap_pkg::SWAP_B] == $past(a_sync_r[dbap_pkg::SWAP_A]);
  endproperty
  a_swap: assert property (p_swap) else $error("Strap swap wrong");

  // High half follows bank B in order.
  property p_bank_b;
    @(posedge clk_i) disable iff (rst_i)
      $rose(strap_done_o) |->
        strap_config_word_o[dbap_pkg::CFG_W-1:dbap_pkg::CFG_HI_LSB] == $past(b_sync_r);
  endproperty
  a_bank_b: assert property (p_bank_b) else $error("Bank B strap wrong");

  // Capture completes a fixed time after reset release.
  property p_capt_done;
    @(posedge clk_i) $fell(rst_i) |-> ##5 strap_done_o;
  endproperty
  a_capt_done: assert property (p_capt_done) else $error("Strap capture late");

  // Unswapped bank A bits pass straight through; the mask drops the swapped pair.
  localparam logic [DW-1:0] A_KEEP =
    ~((DW'(1) << dbap_pkg::SWAP_A) | (DW'(1) << dbap_pkg::SWAP_B));
  property p_bank_a;
    @(posedge clk_i) disable iff (rst_i)
      $rose(strap_done_o) |->
        (strap_config_word_o[DW-1:0] & A_KEEP) == ($past(a_sync_r) & A_KEEP);
  endproperty
  a_bank_a: assert property (p_bank_a) else $error("Bank A strap wrong");

  // A write column pulse drives the column address and write data in the same cycle.
  sequence s_col_issue;
    col_go && q_wr;
  endsequence
  property p_write_issue;
    @(posedge clk_i) disable iff (rst_i)
      s_col_issue |=> !bank_a_write_en_n_o && bank_a_mem_data_oe_o && bank_a_addr_o == $past(q_col)
                      && bank_a_mem_data_o == $past(q_wd);
  endproperty
  a_write_issue: assert property (p_write_issue) else $error("Write cycle wrong");

  // Read returns exactly four cycles after its column pulse starts.
  property p_read_ret;
    @(posedge clk_i) disable iff (rst_i)
      (col_go && !q_wr) |-> ##4 rd_valid_o;
  endproperty
  a_read_ret: assert property (p_read_ret) else $error("Read return late");

  // Lower strobe follows its byte enable.
  property p_lo_be;
    @(posedge clk_i) disable iff (rst_i)
      (col_go && !q_be[0]) |=> bank_a_col_strobe_lo_n_o;
  endproperty
  a_lo_be: assert property (p_lo_be) else $error("Low CAS ignores byte enable");

  property p_hi_be;
    @(posedge clk_i) disable iff (rst_i)
      (col_go && q_be[1]) |=> !bank_a_col_strobe_hi_n_o;
  endproperty
  a_hi_be: assert property (p_hi_be) else $error("High CAS ignores byte enable");
endmodule // dbap_port

/* hdl/dbap_pkg.sv */
package dbap_pkg;

  // Memory organisation.
  localparam int ROW_W = 9;
  localparam int COL_W = 9;
  localparam int DATA_W = 16;
  localparam int CFG_W = 32;
  localparam int BYTE_W = 8;

  // Swapped strap positions in the low configuration half.
  localparam int SWAP_A = 8;
  localparam int SWAP_B = 11;
  localparam int CFG_HI_LSB = 16;

  // Page timing in clock cycles at 20 MHz.
  localparam int CLK_NS = 50;
  localparam int TRP_NS = 100;
  localparam int TRCD_NS = 100;
  localparam int TCAS_NS = 50;
  localparam int TRP_CYC = (TRP_NS + CLK_NS - 1) / CLK_NS;
  localparam int TRCD_CYC = (TRCD_NS + CLK_NS - 1) / CLK_NS;
  localparam int TCAS_CYC = (TCAS_NS + CLK_NS - 1) / CLK_NS;

  // Strap capture holds the data lines released for this many cycles plus one after reset release.
  localparam int STRAP_CYC = 4;
  localparam logic [3:0] CNT_ZERO = 4'h0;

  // Sequencer states.
  typedef enum logic [2:0] {
    DBAP_CAPT = 3'b000,
    DBAP_IDLE = 3'b001,
    DBAP_RCD = 3'b010,
    DBAP_CAS = 3'b011,
    DBAP_CPRE = 3'b100,
    DBAP_RP = 3'b101
  } dbap_state_t;

endpackage

/* hdl/dbap_fifo.sv */
`timescale 1ns/100ps
// Small synchronous FIFO in flip-flops; full and empty come from a count.
module dbap_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("FIFO depth must be a power of two");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;
  logic [AW:0] cnt_nxt;
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  assign out_valid_o = (cnt_r != '0);
  assign out_data_o = mem_r[rp_r];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Storage write.
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wp_r] <= in_data_i;
    end
  end

  // Pointers and occupancy.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_nxt;
    end
  end

  // Ready is a flop fed from the next count, so the port's ready output has no gate behind it.
  assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_ready_o <= 1'b1;
    end else begin
      in_ready_o <= (cnt_nxt != FULL_CNT);
    end
  end

  property p_no_overflow;
    @(posedge clk_i) disable iff (rst_i) cnt_r <= DEPTH;
  endproperty
  a_no_overflow: assert property (p_no_overflow) else $error("FIFO count above depth");
endmodule // dbap_fifo

/* test/dbap_dram_model.sv */
`timescale 1ns/100ps
// Fast-page x16 DRAM on the bank A pins; counts column strobes seen outside an open row.
module dbap_dram_model (
  input wire logic [dbap_pkg::ROW_W-1:0] addr_i,
  input wire logic ras_n_i,
  input wire logic casl_n_i,
  input wire logic cash_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic [dbap_pkg::DATA_W-1:0] dq_i,
  output logic [dbap_pkg::DATA_W-1:0] dq_o,
  output logic [1:0] dq_oe_o,
  output int viol_o
);
  logic [15:0] mem [logic [17:0]];
  logic [8:0] row_r;
  logic [17:0] key;
  initial viol_o = 0;
  initial dq_o = 16'h0000;
  // The row is taken just after RAS falls, once the address has settled.
  always @(negedge ras_n_i) begin
    #1;
    row_r = addr_i;
  end
  // Each strobe owns its byte lane, so a partial write leaves the other lane alone.
  always @(negedge casl_n_i or negedge cash_n_i) begin
    #1;
    key = {row_r, addr_i};
    if (ras_n_i !== 1'b0) viol_o++;
    if (!mem.exists(key)) mem[key] = ~dq_o;
    if (we_n_i === 1'b0 && casl_n_i === 1'b0) mem[key][7:0] = dq_i[7:0];
    if (we_n_i === 1'b0 && cash_n_i === 1'b0) mem[key][15:8] = dq_i[15:8];
    dq_o = mem[key];
  end
  // Read lanes drive while OE and their strobe are low and let go 2 ns after.
  assign #2 dq_oe_o = {~oe_n_i & ~cash_n_i & we_n_i, ~oe_n_i & ~casl_n_i & we_n_i};
endmodule // dbap_dram_model

/* test/tb_top.sv */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, (e), (g)); end end
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req_valid_i = 1'b0;
  logic req_write_i = 1'b0;
  logic [1:0] req_byte_en_i = 2'h0;
  logic [8:0] req_row_i = 9'h000;
  logic [8:0] req_col_i = 9'h000;
  logic [15:0] req_wdata_i = 16'h0000;
  logic [15:0] rd_data_o, a_do, a_bus, m_d, strap_a = 16'hFFFF, strap_b = 16'hFFFF;
  logic [31:0] strap_config_word_o, r;
  logic req_ready_o, rd_valid_o, strap_done_o, a_oe, ras, casl, cash, we, oe;
  logic ras_q = 1'b1;
  logic refused = 1'b0;
  logic [8:0] addr;
  logic [1:0] m_oe;
  int viol, n, k, err_total = 0, checked = 0, cycles = 0;
  integer seed = 32'hE4E38203;
  logic [15:0] ref_mem [logic [17:0]];
  logic [15:0] exp_q[$];
  logic [20:0] ops_q[$];
  logic [17:0] pool[8];

  // Pins resolve to the driver, else to the DRAM's enabled read lanes, else to the strap resistors, which also set the idle level.
  assign a_bus = a_oe ? a_do : ((m_d & {{8{m_oe[1]}}, {8{m_oe[0]}}})
    | (strap_a & ~{{8{m_oe[1]}}, {8{m_oe[0]}}}));

  dbap_port #(.FIFO_DEPTH(16)) uut (.clk_i, .rst_i, .req_valid_i, .req_ready_o, .req_write_i,
    .req_byte_en_i, .req_row_i, .req_col_i, .req_wdata_i, .rd_data_o, .rd_valid_o,
    .strap_config_word_o, .strap_done_o, .bank_a_mem_data_i(a_bus), .bank_a_mem_data_o(a_do),
    .bank_a_mem_data_oe_o(a_oe), .bank_b_mem_data_i(strap_b), .bank_a_addr_o(addr),
    .bank_a_row_strobe_n_o(ras), .bank_a_col_strobe_lo_n_o(casl),
    .bank_a_col_strobe_hi_n_o(cash), .bank_a_write_en_n_o(we), .bank_a_output_en_n_o(oe));
  dbap_dram_model dram (.addr_i(addr), .ras_n_i(ras), .casl_n_i(casl), .cash_n_i(cash),
    .we_n_i(we), .oe_n_i(oe), .dq_i(a_bus), .dq_o(m_d), .dq_oe_o(m_oe), .viol_o(viol));

  // Free-running 20 MHz clock.
  initial begin
    forever #25 clk_i = ~clk_i;
  end

  // A hang ends the run as a failure.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 12000) begin
      err_total++;
      end_sim();
    end
  end

  // Pin monitor: ops are served in order, one CAS cycle each, so the head op is the live one.
  always @(negedge clk_i) begin
    if (!rst_i && strap_done_o !== 1'b1) `CHK("data oe", 1'b0, a_oe)
    if (ops_q.size() > 0 && ras === 1'b0 && ras_q === 1'b1) begin
      `CHK("row addr", ops_q[0][17:9], addr)
    end
    if (ops_q.size() > 0 && (casl === 1'b0 || cash === 1'b0)) begin
      `CHK("col addr", ops_q[0][8:0], addr)
      `CHK("strobes", {~ops_q[0][19:18], ~ops_q[0][20], 1'b0}, {cash, casl, we, ras})
      `CHK("out enable", ops_q[0][20], oe)
      void'(ops_q.pop_front());
    end
    if (rd_valid_o === 1'b1) begin
      `CHK("rd data", exp_q[0], rd_data_o)
      void'(exp_q.pop_front());
    end
    ras_q = ras;
  end

  function automatic logic [31:0] exp_straps(input logic [15:0] a, input logic [15:0] b);
    logic [15:0] s;
    s = a;
    s[dbap_pkg::SWAP_A] = a[dbap_pkg::SWAP_B];
    s[dbap_pkg::SWAP_B] = a[dbap_pkg::SWAP_A];
    return {b, s};
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] d,
    input logic [1:0] be);
    return {be[1] ? d[15:8] : o[15:8], be[0] ? d[7:0] : o[7:0]};
  endfunction

  // Reset with new strap levels, then check idle strobes and the captured word.
  task automatic do_reset(input logic [15:0] sa, input logic [15:0] sb);
    int i;
    @(negedge clk_i);
    rst_i = 1'b1;
    strap_a = sa;
    strap_b = sb;
    repeat (20) @(negedge clk_i);
    `CHK("idle pins", 6'h3E, {ras, casl, cash, we, oe, a_oe})
    rst_i = 1'b0;
    for (i = 0; i < 20 && strap_done_o !== 1'b1; i++) @(negedge clk_i);
    `CHK("strap done", 1'b1, strap_done_o)
    `CHK("strap word", exp_straps(sa, sb), strap_config_word_o)
  endtask

  // Valid stays up between pushes, so back-to-back requests need no idle cycle.
  task automatic push(input logic w, input logic [1:0] be, input logic [17:0] a,
    input logic [15:0] d);
    int i;
    req_valid_i = 1'b1;
    req_write_i = w;
    req_byte_en_i = be;
    {req_row_i, req_col_i} = a;
    req_wdata_i = d;
    for (i = 0; i < 200 && req_ready_o !== 1'b1; i++) begin
      refused = 1'b1;
      @(negedge clk_i);
    end
    `CHK("req ready", 1'b1, req_ready_o)
    ops_q.push_back({w, be, a});
    if (w) ref_mem[a] = merge(ref_mem[a], d, be);
    else exp_q.push_back(ref_mem[a]);
    @(negedge clk_i);
  endtask

  task automatic end_sim();
    if (err_total == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Straps with one swapped bit set, then mixed traffic that overruns the queue.
  initial begin
    do_reset(16'h0800, 16'h0001);
    pool[0] = {9'h1FF, 9'h000};
    pool[1] = {9'h000, 9'h1FF};
    for (n = 2; n < 8; n++) begin
      r = $random(seed);
      pool[n] = {9'(n % 3), r[8:0]};
    end
    for (n = 0; n < 8; n++) begin
      r = $random(seed);
      push(1'b1, 2'h3, pool[n], r[15:0]);
    end
    for (n = 0; n < 300; n++) begin
      r = $random(seed);
      k = r[2:0];
      push(r[3], r[3] ? 2'(1 + r[4] + r[5]) : 2'h3, pool[k], r[31:16]);
    end
    req_valid_i = 1'b0;
    for (n = 0; n < 3000 && ops_q.size() + exp_q.size() > 0; n++) @(negedge clk_i);
    `CHK("queue refused", 1'b1, refused)
    `CHK("drained", 0, ops_q.size() + exp_q.size())
    `CHK("cas outside row", 0, viol)
    do_reset(16'h0100, 16'h8000);
    r = $random(seed);
    do_reset(r[15:0], r[31:16]);
    end_sim();
  end
endmodule // tb_top
